// File: design/eva_cfg.svh
// constants of the engine variable arithmetic block
// assumes it is included once per design file, before any module
//
// Summary of operation
// - each engine owns private 8-bit A and B
// - one shared 8-bit C seen by all engines
// - load immediate overwrites target with operand
// - target code 0 A, 1 B, 2 C
// - add immediate adds constant into target
// - subtract immediate subtracts constant from target
// - add variables sums sources into target
// - sums above 255 wrap through zero
// - subtract variables: first minus second into target
// - differences below zero wrap around from 255
// - source code 0 private A, 1 private B
// - source 2 shared, 3 mapped register value
// - compares skip encoded count when condition holds
`ifndef EVA_CFG_SVH
`define EVA_CFG_SVH

// register offsets on the plain port
`define EVA_OFS_MAP_LO  8'h3C
`define EVA_OFS_MAP_HI  8'h42
`define EVA_OFS_CTRL    8'h70
`define EVA_OFS_E1_A    8'h71
`define EVA_OFS_E1_B    8'h72
`define EVA_OFS_E2_A    8'h73
`define EVA_OFS_E2_B    8'h74
`define EVA_OFS_E3_A    8'h75
`define EVA_OFS_E3_B    8'h76
`define EVA_OFS_C       8'h77

// field positions
`define EVA_CTRL_MAP_SEL 0

// reset values
`define EVA_RST_VAR  8'h00
`define EVA_RST_MAP  8'h00
`define EVA_RST_CTRL 1'b0
`define EVA_RST_RDATA 8'h00

`endif

// File: design/eva_pkg.sv
// types shared by the engine variable arithmetic block
// assumes eva_cfg.svh carries the numeric constants
package eva_pkg;

    // decoded instruction kinds from the sequencer
    typedef enum logic [3:0] {
        EVA_OP_NOP                = 4'h0,
        EVA_OP_LOAD_IMMEDIATE     = 4'h1,
        EVA_OP_ADD_IMMEDIATE      = 4'h2,
        EVA_OP_SUBTRACT_IMMEDIATE = 4'h3,
        EVA_OP_ADD_VARIABLES      = 4'h4,
        EVA_OP_SUBTRACT_VARIABLES = 4'h5,
        EVA_OP_JUMP_NOT_EQUAL     = 4'h6,
        EVA_OP_JUMP_LESS          = 4'h7,
        EVA_OP_JUMP_GREATER_EQUAL = 4'h8,
        EVA_OP_JUMP_EQUAL         = 4'h9
    } eva_op_t;

    // variable selector codes
    typedef enum logic [1:0] {
        EVA_SEL_A   = 2'h0,
        EVA_SEL_B   = 2'h1,
        EVA_SEL_C   = 2'h2,
        EVA_SEL_MAP = 2'h3
    } eva_sel_t;

    typedef struct packed {
        eva_op_t    op;
        eva_sel_t   target;
        eva_sel_t   src1;
        eva_sel_t   src2;
        logic [7:0] imm;
        logic [4:0] skip;
    } eva_instr_t;

    typedef struct packed {
        logic       taken;
        logic [4:0] skip;
    } eva_result_t;

endpackage

// File: design/eva_top.sv
// variable arithmetic datapath shared by three program engines
// assumes decoded instructions arrive from sequencers on CLK
//
// The plain strobed port and the placing of the registers are this design's own decisions.
`timescale 1ns/10ps
`include "eva_cfg.svh"

module eva_top (
    input  wire logic                          CLK,
    input  wire logic                          RST,
    input  wire logic                          CE,
    input  wire logic [2:0]                    VALID,
    input  wire eva_pkg::eva_instr_t [2:0]     INSTR,
    output logic [2:0]                         READY,
    output logic [2:0]                         DONE,
    output eva_pkg::eva_result_t [2:0]         RESULT,
    input  wire logic [7:0]                    ADDR,
    input  wire logic [7:0]                    WDATA,
    input  wire logic                          WR,
    input  wire logic                          RD,
    output logic [7:0]                         RDATA
);
    import eva_pkg::*;

    // variable storage
    logic [2:0][7:0] var_a;
    logic [2:0][7:0] var_b;
    logic [7:0]      var_c;
    logic [2:0][7:0] next_var_a;
    logic [2:0][7:0] next_var_b;
    logic [7:0]      next_var_c;

    // software side registers
    logic [7:0]      map_lo;
    logic [7:0]      map_hi;
    logic            map_sel;
    logic [7:0]      next_map_lo;
    logic [7:0]      next_map_hi;
    logic            next_map_sel;
    logic [7:0]      next_rdata;

    // per engine datapath
    logic [7:0]      map_val;
    logic [2:0][7:0] op_x;
    logic [2:0][7:0] op_y;
    logic [2:0][7:0] res;
    logic [2:0]      writes;
    logic [2:0]      writes_c;
    logic [2:0]      grant;
    logic [2:0]      fire;
    logic [2:0]      cond;
    logic            c_claimed;
    logic [2:0]      next_done;
    eva_result_t [2:0] next_result;

    // pick one operand by selector code
    function automatic logic [7:0] fetch(
        input eva_sel_t   s,
        input logic [7:0] a,
        input logic [7:0] b,
        input logic [7:0] c,
        input logic [7:0] m
    );
        logic [7:0] v;
        case (s)
            EVA_SEL_A: v = a;
            EVA_SEL_B: v = b;
            EVA_SEL_C: v = c;
            default:   v = m;
        endcase
        return v;
    endfunction

    // true for instructions that store into a variable
    function automatic logic is_store(input eva_op_t op);
        return (op == EVA_OP_LOAD_IMMEDIATE) || (op == EVA_OP_ADD_IMMEDIATE) ||
               (op == EVA_OP_SUBTRACT_IMMEDIATE) || (op == EVA_OP_ADD_VARIABLES) ||
               (op == EVA_OP_SUBTRACT_VARIABLES);
    endfunction

    // mapped value: one of two registers chosen by software
    assign map_val = map_sel ? map_hi : map_lo;

    // operands, results, compares and shared-variable arbitration
    always_comb begin
        c_claimed = 1'b0;
        for (int e = 0; e < 3; e++) begin
            op_x[e]     = 8'h00;
            op_y[e]     = 8'h00;
            res[e]      = 8'h00;
            cond[e]     = 1'b0;
            writes[e]   = is_store(INSTR[e].op) && (INSTR[e].target != EVA_SEL_MAP);
            writes_c[e] = writes[e] && (INSTR[e].target == EVA_SEL_C);
            case (INSTR[e].op)
                EVA_OP_LOAD_IMMEDIATE: begin
                    res[e] = INSTR[e].imm;
                end
                EVA_OP_ADD_IMMEDIATE, EVA_OP_SUBTRACT_IMMEDIATE: begin
                    op_x[e] = fetch(INSTR[e].target, var_a[e], var_b[e], var_c, map_val);
                    op_y[e] = INSTR[e].imm;
                    // 8-bit sum or difference drops the carry
                    if (INSTR[e].op == EVA_OP_ADD_IMMEDIATE) begin
                        res[e] = op_x[e] + op_y[e];
                    end else begin
                        res[e] = op_x[e] - op_y[e];
                    end
                end
                EVA_OP_ADD_VARIABLES: begin
                    op_x[e] = fetch(INSTR[e].src1, var_a[e], var_b[e], var_c, map_val);
                    op_y[e] = fetch(INSTR[e].src2, var_a[e], var_b[e], var_c, map_val);
                    res[e]  = op_x[e] + op_y[e];
                end
                EVA_OP_SUBTRACT_VARIABLES: begin
                    op_x[e] = fetch(INSTR[e].src1, var_a[e], var_b[e], var_c, map_val);
                    op_y[e] = fetch(INSTR[e].src2, var_a[e], var_b[e], var_c, map_val);
                    res[e]  = op_x[e] - op_y[e];
                end
                EVA_OP_JUMP_NOT_EQUAL, EVA_OP_JUMP_LESS,
                EVA_OP_JUMP_GREATER_EQUAL, EVA_OP_JUMP_EQUAL: begin
                    op_x[e] = fetch(INSTR[e].src1, var_a[e], var_b[e], var_c, map_val);
                    op_y[e] = fetch(INSTR[e].src2, var_a[e], var_b[e], var_c, map_val);
                    case (INSTR[e].op)
                        EVA_OP_JUMP_NOT_EQUAL:     cond[e] = op_x[e] != op_y[e];
                        EVA_OP_JUMP_LESS:          cond[e] = op_x[e] < op_y[e];
                        EVA_OP_JUMP_GREATER_EQUAL: cond[e] = op_x[e] >= op_y[e];
                        default:                   cond[e] = op_x[e] == op_y[e];
                    endcase
                end
                default: begin
                    res[e] = 8'h00;
                end
            endcase
            // lowest engine wins the shared variable, the other engines storing C wait for a later cycle
            grant[e]  = VALID[e] && !(writes_c[e] && c_claimed);
            c_claimed = c_claimed || (VALID[e] && writes_c[e]);
        end
    end

    // handshake: nothing is taken while the block is frozen
    assign fire  = grant & {3{CE}};
    assign READY = fire;

    // next variable contents
    always_comb begin
        next_var_a = var_a;
        next_var_b = var_b;
        next_var_c = var_c;
        for (int e = 0; e < 3; e++) begin
            // an engine touches only its own A and B slots and the shared C
            if (fire[e] && writes[e]) begin
                case (INSTR[e].target)
                    EVA_SEL_A: next_var_a[e] = res[e];
                    EVA_SEL_B: next_var_b[e] = res[e];
                    EVA_SEL_C: next_var_c    = res[e];
                    default:   next_var_c    = next_var_c;
                endcase
            end
        end
    end

    // variables update on the accepting edge, on the same edge as done
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            var_a <= {3{`EVA_RST_VAR}};
            var_b <= {3{`EVA_RST_VAR}};
            var_c <= `EVA_RST_VAR;
        end else if (CE) begin
            var_a <= next_var_a;
            var_b <= next_var_b;
            var_c <= next_var_c;
        end
    end

    // completion and jump outcome for each engine
    always_comb begin
        for (int e = 0; e < 3; e++) begin
            next_done[e]         = fire[e];
            next_result[e].taken = fire[e] && cond[e];
            next_result[e].skip  = (fire[e] && cond[e]) ? INSTR[e].skip : 5'h00;
        end
    end

    // done is one cycle after accept, so the sequencer sees fresh variables
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            DONE   <= 3'h0;
            RESULT <= '0;
        end else if (CE) begin
            DONE   <= next_done;
            RESULT <= next_result;
        end
    end

    // software register writes and read data
    always_comb begin
        next_map_lo  = map_lo;
        next_map_hi  = map_hi;
        next_map_sel = map_sel;
        next_rdata   = RDATA;
        if (WR) begin
            case (ADDR)
                `EVA_OFS_MAP_LO: next_map_lo  = WDATA;
                `EVA_OFS_MAP_HI: next_map_hi  = WDATA;
                `EVA_OFS_CTRL:   next_map_sel = WDATA[`EVA_CTRL_MAP_SEL];
                default:         next_map_sel = map_sel;
            endcase
        end
        if (RD) begin
            case (ADDR)
                `EVA_OFS_MAP_LO: next_rdata = map_lo;
                `EVA_OFS_MAP_HI: next_rdata = map_hi;
                `EVA_OFS_CTRL:   next_rdata = {7'h00, map_sel};
                `EVA_OFS_E1_A:   next_rdata = var_a[0];
                `EVA_OFS_E1_B:   next_rdata = var_b[0];
                `EVA_OFS_E2_A:   next_rdata = var_a[1];
                `EVA_OFS_E2_B:   next_rdata = var_b[1];
                `EVA_OFS_E3_A:   next_rdata = var_a[2];
                `EVA_OFS_E3_B:   next_rdata = var_b[2];
                `EVA_OFS_C:      next_rdata = var_c;
                default:         next_rdata = 8'h00; // unmapped reads zero
            endcase
        end
    end

    // register file; reads show variables as of the strobe cycle
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            map_lo  <= `EVA_RST_MAP;
            map_hi  <= `EVA_RST_MAP;
            map_sel <= `EVA_RST_CTRL;
            RDATA   <= `EVA_RST_RDATA;
        end else if (CE) begin
            map_lo  <= next_map_lo;
            map_hi  <= next_map_hi;
            map_sel <= next_map_sel;
            RDATA   <= next_rdata;
        end
    end

    // checks on the datapath and its handshake
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RST);

    property p_load_a0;
        fire[0] && INSTR[0].op == EVA_OP_LOAD_IMMEDIATE && INSTR[0].target == EVA_SEL_A
        |=> var_a[0] == $past(INSTR[0].imm);
    endproperty
    a_load_a0: assert property (p_load_a0)
        else $error("load immediate did not reach variable A");

    property p_private;
        CE && !(fire[0] && writes[0] && INSTR[0].target == EVA_SEL_B)
        |=> var_b[0] == $past(var_b[0]);
    endproperty
    a_private: assert property (p_private)
        else $error("private B changed without its own engine");

    property p_shared;
        fire[2] && writes_c[2] |=> var_c == $past(res[2]) ##1 (!CE || var_c == $past(var_c) ||
            $past(fire[0] || fire[1] || fire[2]));
    endproperty
    a_shared: assert property (p_shared)
        else $error("shared variable write lost");

    property p_add_imm;
        fire[1] && INSTR[1].op == EVA_OP_ADD_IMMEDIATE && INSTR[1].target == EVA_SEL_B
        |=> var_b[1] == 8'($past(var_b[1]) + $past(INSTR[1].imm));
    endproperty
    a_add_imm: assert property (p_add_imm)
        else $error("add immediate result wrong");

    property p_sub_imm;
        fire[0] && INSTR[0].op == EVA_OP_SUBTRACT_IMMEDIATE && INSTR[0].target == EVA_SEL_A
        |=> var_a[0] == 8'($past(var_a[0]) - $past(INSTR[0].imm));
    endproperty
    a_sub_imm: assert property (p_sub_imm)
        else $error("subtract immediate result wrong");

    property p_add_var;
        fire[0] && INSTR[0].op == EVA_OP_ADD_VARIABLES && INSTR[0].target == EVA_SEL_C &&
        INSTR[0].src1 == EVA_SEL_A && INSTR[0].src2 == EVA_SEL_B
        |=> var_c == 8'($past(var_a[0]) + $past(var_b[0]));
    endproperty
    a_add_var: assert property (p_add_var)
        else $error("add variables result wrong");

    property p_sub_var;
        fire[0] && INSTR[0].op == EVA_OP_SUBTRACT_VARIABLES && INSTR[0].target == EVA_SEL_A &&
        INSTR[0].src1 == EVA_SEL_B && INSTR[0].src2 == EVA_SEL_MAP
        |=> var_a[0] == 8'($past(var_b[0]) - $past(map_val));
    endproperty
    a_sub_var: assert property (p_sub_var)
        else $error("subtract variables result wrong");

    property p_jump;
        fire[1] && INSTR[1].op == EVA_OP_JUMP_EQUAL && op_x[1] == op_y[1]
        |=> DONE[1] && RESULT[1].taken && RESULT[1].skip == $past(INSTR[1].skip);
    endproperty
    a_jump: assert property (p_jump)
        else $error("taken compare lost its skip count");

    property p_no_jump;
        fire[2] && INSTR[2].op == EVA_OP_JUMP_LESS && op_x[2] >= op_y[2]
        |=> DONE[2] && !RESULT[2].taken;
    endproperty
    a_no_jump: assert property (p_no_jump)
        else $error("compare jumped on a false condition");

    property p_done;
        CE && !fire[0] |=> !DONE[0];
    endproperty
    a_done: assert property (p_done)
        else $error("done without an accepted instruction");

    property p_c_arb;
        CE && VALID[0] && VALID[1] && writes_c[0] && writes_c[1] |-> fire[0] && !fire[1];
    endproperty
    a_c_arb: assert property (p_c_arb)
        else $error("two engines wrote the shared variable at once");

    // a frozen block must not take a request it cannot complete
    property p_ce_ready;
        !CE |-> READY == 3'h0;
    endproperty
    a_ce_ready: assert property (p_ce_ready)
        else $error("request taken while frozen");

    property p_ce_hold;
        !CE |=> $stable(var_a) && $stable(var_b) && $stable(var_c) && $stable(DONE) && $stable(RDATA);
    endproperty
    a_ce_hold: assert property (p_ce_hold)
        else $error("state moved while frozen");

    property p_map_store;
        fire[2] && INSTR[2].target == EVA_SEL_MAP |=> $stable(var_a[2]) && $stable(var_b[2]);
    endproperty
    a_map_store: assert property (p_map_store)
        else $error("store to code 3 changed a private variable");

    // while enabled, only a shared-variable clash may hold an engine back
    property p_refuse_only_c;
        CE && VALID[1] && !writes_c[1] |-> READY[1];
    endproperty
    a_refuse_only_c: assert property (p_refuse_only_c)
        else $error("engine refused without a shared-variable clash");

    property p_store_result;
        fire[0] && writes[0] |=> DONE[0] && !RESULT[0].taken && RESULT[0].skip == 5'h00;
    endproperty
    a_store_result: assert property (p_store_result)
        else $error("store reported a jump outcome");

endmodule

// File: bench/eva_seq_model.sv
// sequencer stand-in for one engine: holds a decoded instruction until taken
// assumes the engine samples valid and ready on the rising edge of clk
`timescale 1ns/10ps

module eva_seq_model (
    input  wire logic                clk,
    input  wire logic                rst,
    input  wire logic                go,
    input  wire eva_pkg::eva_instr_t new_instr,
    input  wire logic                ready,
    output logic                     valid,
    output eva_pkg::eva_instr_t      instr
);
    import eva_pkg::*;

    // request held until accepted; a released word is inverted so stale fields never match
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            valid <= 1'b0;
            instr <= '0;
        end else if (valid && ready) begin
            valid <= 1'b0;
            instr <= eva_instr_t'(~instr);
        end else if (go) begin
            valid <= 1'b1;
            instr <= new_instr;
        end
    end
endmodule

// File: bench/eva_top_tb.sv
// bench for eva_top: three sequencer models feed the engines, register port reads back
// assumes eva_pkg and eva_seq_model are compiled first
`timescale 1ns/10ps

module eva_top_tb;
    import eva_pkg::*;

    logic              clk = 1'b0;
    logic              rst = 1'b1;
    logic              ce = 1'b1;
    logic [2:0]        go = 3'h0;
    logic [2:0]        valid;
    eva_instr_t [2:0]  instr;
    eva_instr_t        nin [3] = '{default: '0};
    logic [2:0]        ready;
    logic [2:0]        done;
    eva_result_t [2:0] result;
    logic [7:0]        addr = 8'h00;
    logic [7:0]        wdata = 8'h00;
    logic              wr = 1'b0;
    logic              rd = 1'b0;
    logic [7:0]        rdata;
    logic [7:0]        ea [3] = '{default: 8'h00};
    logic [7:0]        eb [3] = '{default: 8'h00};
    logic [7:0]        ec = 8'h00;
    logic [7:0]        lo = 8'h00;
    logic [7:0]        hi = 8'h00;
    logic              ctl = 1'b0;
    int                err_total = 0;
    int                n_tests = 0;
    localparam logic [7:0] RST_ADDR [11] = '{8'h3C, 8'h42, 8'h70, 8'h71, 8'h72, 8'h73, 8'h74, 8'h75,
                                             8'h76, 8'h77, 8'h10};

    // free-running 125 MHz clock
    always #4 clk = ~clk;

    eva_top dut (
        .CLK    (clk),
        .RST    (rst),
        .CE     (ce),
        .VALID  (valid),
        .INSTR  (instr),
        .READY  (ready),
        .DONE   (done),
        .RESULT (result),
        .ADDR   (addr),
        .WDATA  (wdata),
        .WR     (wr),
        .RD     (rd),
        .RDATA  (rdata)
    );

    // one sequencer per engine
    for (genvar g = 0; g < 3; g++) begin : g_seq
        eva_seq_model u_seq (
            .clk       (clk),
            .rst       (rst),
            .go        (go[g]),
            .new_instr (nin[g]),
            .ready     (ready[g]),
            .valid     (valid[g]),
            .instr     (instr[g])
        );
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // read data appears in the cycle after the strobe and holds until the next read
    task automatic reg_rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(rdata, exp);
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    function automatic logic [7:0] sv(input int e, input eva_sel_t s);
        case (s)
            EVA_SEL_A: return ea[e];
            EVA_SEL_B: return eb[e];
            EVA_SEL_C: return ec;
            default:   return ctl ? hi : lo;
        endcase
    endfunction

    // runs one instruction, checks its done timing and jump outcome and updates the expected variables
    task automatic ex(input int e, input eva_op_t op, input eva_sel_t t, input eva_sel_t s1,
                      input eva_sel_t s2, input logic [7:0] imm);
        logic [7:0] x1, x2, xt, r;
        logic       tk;
        int         n;
        x1 = sv(e, s1);
        x2 = sv(e, s2);
        xt = sv(e, t);
        tk = (op == EVA_OP_JUMP_NOT_EQUAL && x1 != x2) || (op == EVA_OP_JUMP_LESS && x1 < x2) ||
             (op == EVA_OP_JUMP_GREATER_EQUAL && x1 >= x2) || (op == EVA_OP_JUMP_EQUAL && x1 == x2);
        case (op)
            EVA_OP_LOAD_IMMEDIATE:     r = imm;
            EVA_OP_ADD_IMMEDIATE:      r = xt + imm;
            EVA_OP_SUBTRACT_IMMEDIATE: r = xt - imm;
            EVA_OP_ADD_VARIABLES:      r = x1 + x2;
            EVA_OP_SUBTRACT_VARIABLES: r = x1 - x2;
            default:                   r = xt;
        endcase
        @(posedge clk);
        nin[e] <= '{op, t, s1, s2, imm, imm[4:0]};
        go[e]  <= 1'b1;
        @(posedge clk);
        go[e] <= 1'b0;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (done[e] !== 1'b1 && n < 10);
        chk(8'(n), 8'h01);
        chk({7'h00, result[e].taken}, {7'h00, tk});
        if (tk) chk({3'h0, result[e].skip}, {3'h0, imm[4:0]});
        if (t == EVA_SEL_A) ea[e] = r;
        else if (t == EVA_SEL_B) eb[e] = r;
        else if (t == EVA_SEL_C) ec = r;
    endtask

    task automatic chk_all();
        for (int e = 0; e < 3; e++) begin
            reg_rd(8'h71 + 8'(2 * e), ea[e]);
            reg_rd(8'h72 + 8'(2 * e), eb[e]);
        end
        reg_rd(8'h77, ec);
    endtask

    task automatic complete_run();
        $display("comparisons=%0d mismatches=%0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // watchdog far beyond the two hundred or so cycles the sequence needs
    initial begin
        #100000;
        err_total++;
        complete_run();
    end

    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        foreach (RST_ADDR[i]) reg_rd(RST_ADDR[i], 8'h00);
        ex(0, EVA_OP_LOAD_IMMEDIATE, EVA_SEL_A, EVA_SEL_A, EVA_SEL_A, 8'hF0);
        ex(0, EVA_OP_LOAD_IMMEDIATE, EVA_SEL_B, EVA_SEL_A, EVA_SEL_A, 8'h10);
        ex(1, EVA_OP_LOAD_IMMEDIATE, EVA_SEL_A, EVA_SEL_A, EVA_SEL_A, 8'h64);
        ex(2, EVA_OP_LOAD_IMMEDIATE, EVA_SEL_B, EVA_SEL_A, EVA_SEL_A, 8'hFF);
        chk_all();
        ex(0, EVA_OP_ADD_IMMEDIATE, EVA_SEL_A, EVA_SEL_A, EVA_SEL_A, 8'h20);
        ex(0, EVA_OP_SUBTRACT_IMMEDIATE, EVA_SEL_B, EVA_SEL_A, EVA_SEL_A, 8'h20);
        ex(1, EVA_OP_LOAD_IMMEDIATE, EVA_SEL_C, EVA_SEL_A, EVA_SEL_A, 8'h80);
        reg_wr(8'h3C, 8'h05);
        lo = 8'h05;
        ex(2, EVA_OP_ADD_VARIABLES, EVA_SEL_A, EVA_SEL_C, EVA_SEL_MAP, 8'h00);
        ex(2, EVA_OP_ADD_VARIABLES, EVA_SEL_C, EVA_SEL_C, EVA_SEL_C, 8'h00);
        reg_wr(8'h42, 8'hFF);
        reg_wr(8'h70, 8'h01);
        hi = 8'hFF;
        ctl = 1'b1;
        ex(1, EVA_OP_SUBTRACT_VARIABLES, EVA_SEL_B, EVA_SEL_A, EVA_SEL_MAP, 8'h00);
        ex(0, EVA_OP_SUBTRACT_VARIABLES, EVA_SEL_C, EVA_SEL_B, EVA_SEL_A, 8'h00);
        ex(2, EVA_OP_ADD_IMMEDIATE, EVA_SEL_MAP, EVA_SEL_A, EVA_SEL_A, 8'h01);
        reg_wr(8'h71, 8'hAA);
        chk_all();
        reg_rd(8'h70, 8'h01);
        reg_rd(8'h42, 8'hFF);
        // every compare, once unequal and once equal, with the largest skip
        for (int k = 0; k < 4; k++) begin
            ex(0, eva_op_t'(4'h6 + 4'(k)), EVA_SEL_A, EVA_SEL_A, EVA_SEL_B, 8'h1F);
            ex(0, eva_op_t'(4'h6 + 4'(k)), EVA_SEL_A, EVA_SEL_B, EVA_SEL_B, 8'h1F);
        end
        // the other engines and forms, with wrap in both directions
        ex(1, EVA_OP_ADD_IMMEDIATE, EVA_SEL_B, EVA_SEL_A, EVA_SEL_A, 8'h9B);
        ex(0, EVA_OP_SUBTRACT_IMMEDIATE, EVA_SEL_A, EVA_SEL_A, EVA_SEL_A, 8'h11);
        ex(0, EVA_OP_ADD_VARIABLES, EVA_SEL_C, EVA_SEL_A, EVA_SEL_B, 8'h00);
        ex(0, EVA_OP_SUBTRACT_VARIABLES, EVA_SEL_A, EVA_SEL_B, EVA_SEL_MAP, 8'h00);
        ex(1, EVA_OP_JUMP_EQUAL, EVA_SEL_A, EVA_SEL_B, EVA_SEL_B, 8'h07);
        ex(2, EVA_OP_JUMP_LESS, EVA_SEL_A, EVA_SEL_B, EVA_SEL_A, 8'h03);
        ex(1, EVA_OP_NOP, EVA_SEL_A, EVA_SEL_A, EVA_SEL_A, 8'h00);
        chk_all();
        // frozen block takes nothing; the held request goes through once enabled
        @(posedge clk);
        ce     <= 1'b0;
        nin[2] <= '{EVA_OP_LOAD_IMMEDIATE, EVA_SEL_A, EVA_SEL_A, EVA_SEL_A, 8'h5A, 5'h00};
        go     <= 3'h4;
        @(posedge clk);
        go <= 3'h0;
        repeat (2) @(posedge clk);
        #1;
        chk({5'h00, ready}, 8'h00);
        chk({5'h00, done}, 8'h00);
        @(posedge clk);
        ce <= 1'b1;
        @(posedge clk);
        #1;
        chk({7'h00, done[2]}, 8'h01);
        ea[2] = 8'h5A;
        // engines 0 and 1 store C in one cycle; the lower engine is taken first
        @(posedge clk);
        nin[0] <= '{EVA_OP_LOAD_IMMEDIATE, EVA_SEL_C, EVA_SEL_A, EVA_SEL_A, 8'h11, 5'h00};
        nin[1] <= '{EVA_OP_LOAD_IMMEDIATE, EVA_SEL_C, EVA_SEL_A, EVA_SEL_A, 8'h22, 5'h00};
        go     <= 3'h3;
        @(posedge clk);
        go <= 3'h0;
        #1;
        chk({6'h00, ready[1:0]}, 8'h01);
        repeat (4) @(posedge clk);
        ec = 8'h22;
        chk_all();
        complete_run();
    end
endmodule
